// ==== rtl/serial_pkg.sv ====
/*
  Shared constants and state types for the dual serial port block.
  Assumes a 10 MHz system clock and word-aligned byte register offsets on the bus.
*/
package serial_pkg;

  // register indices; byte address = 4 * index
  localparam logic [7:0] P0_CTRL_IDX = 8'h98;
  localparam logic [7:0] P0_BUF_IDX = 8'h99;
  localparam logic [7:0] P1_CTRL_IDX = 8'hC0;
  localparam logic [7:0] P1_BUF_IDX = 8'hC1;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BUF_RESET = 8'h00;

  // control field positions
  localparam int B_MODE_HI = 7;
  localparam int B_MODE_LO = 6;
  localparam int B_MULTIPROC = 5;
  localparam int B_RX_EN = 4;
  localparam int B_TX_NINTH = 3;
  localparam int B_RX_NINTH = 2;
  localparam int B_TX_DONE = 1;
  localparam int B_RX_DONE = 0;

  localparam logic [1:0] MODE_0 = 2'h0;
  localparam logic [1:0] MODE_1 = 2'h1;
  localparam logic [1:0] MODE_2 = 2'h2;

  // mode 0 bit clock divisors in system clocks
  localparam logic [3:0] M0_DIV_SLOW = 4'hC;
  localparam logic [3:0] M0_DIV_FAST = 4'h4;
  localparam logic [3:0] M0_BITS = 4'h8;

  // asynchronous framing, 16 ticks per bit
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] SMP_FIRST = 4'h7;
  localparam logic [3:0] SMP_SECOND = 4'h8;
  localparam logic [3:0] SMP_DECIDE = 4'h9;
  localparam logic [3:0] LEFT_MODE1 = 4'h9;
  localparam logic [3:0] LEFT_MODE23 = 4'hA;
  localparam logic [3:0] RX_COMMIT_BIT = 4'h9;

  // mode 2 tick prescale: tick every 2 or 4 clocks
  localparam logic [1:0] PRE_FAST = 2'h1;
  localparam logic [1:0] PRE_SLOW = 2'h3;

  typedef enum logic [3:0] {
    ENG_IDLE = 4'h1,
    ENG_ATX = 4'h2,
    ENG_M0TX = 4'h4,
    ENG_M0RX = 4'h8
  } eng_e;

  typedef enum logic [1:0] {
    RXS_IDLE = 2'h1,
    RXS_BUSY = 2'h2
  } rxs_e;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] rx_hold;
    eng_e eng;
    rxs_e rxs;
    logic [9:0] tx_sh;
    logic [3:0] tx_left;
    logic [3:0] tx_ph;
    logic [3:0] m0_cnt;
    logic [7:0] rx_sh;
    logic [3:0] rx_bit;
    logic [3:0] rx_ph;
    logic [1:0] smp;
    logic [1:0] pre;
    logic [2:0] sync;
    logic tx_pin;
    logic d_out;
    logic d_oe;
  } port_s;

  typedef struct packed {
    port_s [1:0] p;
    logic wait_req;
    logic [7:0] rdata;
  } top_s;

endpackage : serial_pkg

// ==== rtl/dual_serial_port_control.sv ====
/*
  Two identical serial ports with control and data buffer registers on an
  Avalon-MM slave with waitrequest. Baud ticks for modes 1 and 3 come from
  an external timer on the same clock; pins are synchronised here.
*/
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module dual_serial_port_control (
  input wire logic mclk_i,               // system clock
  input wire logic rstn_i,               // sync reset, active low
  input wire logic [9:0] address_i,      // byte address
  input wire logic read_i,               // read request
  input wire logic write_i,              // write request
  input wire logic [31:0] writedata_i,   // write data
  input wire logic [3:0] byteenable_i,   // byte lanes
  output logic [31:0] readdata_o,        // read data
  output logic waitrequest_o,            // stall
  input wire logic [1:0] sample_tick_i,  // 16x tick, modes 1/3
  input wire logic [1:0] double_rate_i,  // mode 2 rate select
  output logic port0_tx_pin_o,           // tx data or mode 0 clock
  input wire logic port0_data_pin_i,     // rx data pin in
  output logic port0_data_pin_o,         // mode 0 data out
  output logic port0_data_pin_oe_o,      // mode 0 data drive
  output logic port0_tx_done_o,          // tx done flag
  output logic port0_rx_done_o,          // rx done flag
  output logic port1_tx_pin_o,           // tx data or mode 0 clock
  input wire logic port1_data_pin_i,     // rx data pin in
  output logic port1_data_pin_o,         // mode 0 data out
  output logic port1_data_pin_oe_o,      // mode 0 data drive
  output logic port1_tx_done_o,          // tx done flag
  output logic port1_rx_done_o           // rx done flag
);

  serial_pkg::top_s s_q;
  serial_pkg::top_s s_d;
  logic [1:0] pin_in;

  assign pin_in = {port1_data_pin_i, port0_data_pin_i};

  always_comb begin
    serial_pkg::port_s n;
    logic [7:0] idx;
    logic [7:0] wdata;
    logic [7:0] rd;
    logic wr_now;
    logic [1:0] mode;
    logic mp;
    logic rxv;
    logic fell;
    logic tick;
    logic b;
    logic load;
    logic [3:0] div;
    logic [3:0] half;
    logic [1:0] pre_top;
    s_d = s_q;
    n = s_q.p[0];
    idx = address_i[9:2];
    wdata = writedata_i[7:0];
    rd = 8'h00;
    mode = 2'h0;
    mp = 1'b0;
    rxv = 1'b0;
    fell = 1'b0;
    tick = 1'b0;
    b = 1'b0;
    load = 1'b0;
    div = 4'h0;
    half = 4'h0;
    pre_top = 2'h0;
    // one wait cycle, then the answer
    s_d.wait_req = ~((read_i | write_i) & s_q.wait_req);
    wr_now = write_i & ~s_q.wait_req & byteenable_i[0];
    if (read_i & s_q.wait_req) begin
      case (idx)
        serial_pkg::P0_CTRL_IDX: rd = s_q.p[0].ctrl;
        serial_pkg::P0_BUF_IDX: rd = s_q.p[0].rx_hold;
        serial_pkg::P1_CTRL_IDX: rd = s_q.p[1].ctrl;
        serial_pkg::P1_BUF_IDX: rd = s_q.p[1].rx_hold;
        default: rd = 8'h00;
      endcase
      s_d.rdata = rd;
    end
    for (int i = 0; i < 2; i++) begin
      n = s_q.p[i];
      n.sync = {n.sync[1:0], pin_in[i]};
      rxv = s_q.p[i].sync[1];
      fell = s_q.p[i].sync[2] & ~s_q.p[i].sync[1];
      if (wr_now && idx == ((i == 0) ? serial_pkg::P0_CTRL_IDX : serial_pkg::P1_CTRL_IDX)) begin
        n.ctrl = wdata;
      end
      load = wr_now && idx == ((i == 0) ? serial_pkg::P0_BUF_IDX : serial_pkg::P1_BUF_IDX);
      mode = n.ctrl[serial_pkg::B_MODE_HI:serial_pkg::B_MODE_LO];
      mp = n.ctrl[serial_pkg::B_MULTIPROC];
      div = mp ? serial_pkg::M0_DIV_FAST : serial_pkg::M0_DIV_SLOW;
      half = {1'b0, div[3:1]};
      pre_top = double_rate_i[i] ? serial_pkg::PRE_FAST : serial_pkg::PRE_SLOW;
      if (n.pre == pre_top) begin
        n.pre = 2'h0;
      end else begin
        n.pre = n.pre + 2'h1;
      end
      if (mode == serial_pkg::MODE_2) begin
        tick = (s_q.p[i].pre == pre_top);
      end else begin
        tick = sample_tick_i[i];
      end

      // transmit / mode 0 shift engine
      unique case (n.eng)
        serial_pkg::ENG_IDLE: begin
          n.tx_pin = 1'b1;
          n.d_oe = 1'b0;
          if (load && mode == serial_pkg::MODE_0) begin
            n.eng = serial_pkg::ENG_M0TX;
            n.tx_sh = {2'h3, wdata};
            n.tx_left = serial_pkg::M0_BITS;
            n.m0_cnt = 4'h0;
            n.d_oe = 1'b1;
            n.d_out = wdata[0];
            n.tx_pin = 1'b0;
          end else if (load) begin
            n.eng = serial_pkg::ENG_ATX;
            n.tx_pin = 1'b0;
            n.tx_ph = 4'h0;
            if (mode == serial_pkg::MODE_1) begin
              n.tx_sh = {2'h3, wdata};
              n.tx_left = serial_pkg::LEFT_MODE1;
            end else begin
              n.tx_sh = {1'b1, n.ctrl[serial_pkg::B_TX_NINTH], wdata};
              n.tx_left = serial_pkg::LEFT_MODE23;
            end
          end else if (mode == serial_pkg::MODE_0 && n.ctrl[serial_pkg::B_RX_EN]
                       && !n.ctrl[serial_pkg::B_RX_DONE]) begin
            n.eng = serial_pkg::ENG_M0RX;
            n.tx_left = serial_pkg::M0_BITS;
            n.m0_cnt = 4'h0;
            n.tx_pin = 1'b0;
          end
        end
        serial_pkg::ENG_ATX: begin
          if (tick) begin
            n.tx_ph = n.tx_ph + 4'h1;
            if (s_q.p[i].tx_ph == serial_pkg::OVS_LAST) begin
              if (n.tx_left == 4'h0) begin
                n.eng = serial_pkg::ENG_IDLE;
                n.tx_pin = 1'b1;
              end else begin
                n.tx_pin = n.tx_sh[0];
                n.tx_sh = {1'b1, n.tx_sh[9:1]};
                n.tx_left = n.tx_left - 4'h1;
                if (n.tx_left == 4'h0) begin
                  n.ctrl[serial_pkg::B_TX_DONE] = 1'b1;
                end
              end
            end
          end
        end
        serial_pkg::ENG_M0TX, serial_pkg::ENG_M0RX: begin
          n.m0_cnt = n.m0_cnt + 4'h1;
          if (s_q.p[i].m0_cnt == half - 4'h1) begin
            n.tx_pin = 1'b1;
            if (n.eng == serial_pkg::ENG_M0RX) begin
              n.rx_sh = {rxv, n.rx_sh[7:1]};
            end
          end
          if (s_q.p[i].m0_cnt == div - 4'h1) begin
            n.m0_cnt = 4'h0;
            n.tx_left = n.tx_left - 4'h1;
            if (n.tx_left == 4'h0) begin
              if (n.eng == serial_pkg::ENG_M0TX) begin
                n.ctrl[serial_pkg::B_TX_DONE] = 1'b1;
              end else begin
                n.rx_hold = n.rx_sh;
                n.ctrl[serial_pkg::B_RX_DONE] = 1'b1;
              end
              n.eng = serial_pkg::ENG_IDLE;
              n.d_oe = 1'b0;
            end else begin
              n.tx_pin = 1'b0;
              n.tx_sh = {1'b1, n.tx_sh[9:1]};
              n.d_out = n.tx_sh[0];
            end
          end
        end
        default: begin
          n.eng = serial_pkg::ENG_IDLE;
        end
      endcase

      // asynchronous receiver
      unique case (n.rxs)
        serial_pkg::RXS_IDLE: begin
          if (mode != serial_pkg::MODE_0 && n.ctrl[serial_pkg::B_RX_EN] && fell) begin
            n.rxs = serial_pkg::RXS_BUSY;
            n.rx_ph = 4'h0;
            n.rx_bit = 4'h0;
          end
        end
        serial_pkg::RXS_BUSY: begin
          if (!n.ctrl[serial_pkg::B_RX_EN] || mode == serial_pkg::MODE_0) begin
            n.rxs = serial_pkg::RXS_IDLE;
          end else if (tick) begin
            n.rx_ph = n.rx_ph + 4'h1;
            if (s_q.p[i].rx_ph == serial_pkg::SMP_FIRST || s_q.p[i].rx_ph == serial_pkg::SMP_SECOND) begin
              n.smp = {n.smp[0], rxv};
            end
            if (s_q.p[i].rx_ph == serial_pkg::SMP_DECIDE) begin
              b = (n.smp[1] & n.smp[0]) | (n.smp[1] & rxv) | (n.smp[0] & rxv);
              n.rx_bit = n.rx_bit + 4'h1;
              if (s_q.p[i].rx_bit == 4'h0) begin
                if (b) begin
                  n.rxs = serial_pkg::RXS_IDLE;
                end
              end else if (s_q.p[i].rx_bit < serial_pkg::RX_COMMIT_BIT) begin
                n.rx_sh = {b, n.rx_sh[7:1]};
              end else if (s_q.p[i].rx_bit == serial_pkg::RX_COMMIT_BIT) begin
                // stop bit in mode 1, ninth bit in modes 2/3
                if (!n.ctrl[serial_pkg::B_RX_DONE] && (!mp || b)) begin
                  n.rx_hold = n.rx_sh;
                  n.ctrl[serial_pkg::B_RX_NINTH] = b;
                  n.ctrl[serial_pkg::B_RX_DONE] = 1'b1;
                end
                if (mode == serial_pkg::MODE_1) begin
                  n.rxs = serial_pkg::RXS_IDLE;
                end
              end else begin
                n.rxs = serial_pkg::RXS_IDLE;
              end
            end
          end
        end
        default: begin
          n.rxs = serial_pkg::RXS_IDLE;
        end
      endcase
      s_d.p[i] = n;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      s_q <= '0;
      s_q.wait_req <= 1'b1;
      for (int i = 0; i < 2; i++) begin
        s_q.p[i].ctrl <= serial_pkg::CTRL_RESET;
        s_q.p[i].rx_hold <= serial_pkg::BUF_RESET;
        s_q.p[i].eng <= serial_pkg::ENG_IDLE;
        s_q.p[i].rxs <= serial_pkg::RXS_IDLE;
        s_q.p[i].tx_pin <= 1'b1;
        s_q.p[i].sync <= 3'h7;
      end
    end else begin
      s_q <= s_d;
    end
  end

  assign readdata_o = {24'h000000, s_q.rdata};
  assign waitrequest_o = s_q.wait_req;
  assign port0_tx_pin_o = s_q.p[0].tx_pin;
  assign port0_data_pin_o = s_q.p[0].d_out;
  assign port0_data_pin_oe_o = s_q.p[0].d_oe;
  assign port0_tx_done_o = s_q.p[0].ctrl[serial_pkg::B_TX_DONE];
  assign port0_rx_done_o = s_q.p[0].ctrl[serial_pkg::B_RX_DONE];
  assign port1_tx_pin_o = s_q.p[1].tx_pin;
  assign port1_data_pin_o = s_q.p[1].d_out;
  assign port1_data_pin_oe_o = s_q.p[1].d_oe;
  assign port1_tx_done_o = s_q.p[1].ctrl[serial_pkg::B_TX_DONE];
  assign port1_rx_done_o = s_q.p[1].ctrl[serial_pkg::B_RX_DONE];

endmodule : dual_serial_port_control

`default_nettype wire

// ==== sim/serial_checker_assertions.sv ====
/* checker for dual_serial_port_control: bus handshake and flag and pin relations.
   assumes only the top ports; bound at the foot of this file. */
`timescale 1ns/100ps
`default_nettype none
module serial_checker (
  input wire logic mclk_i,  // clock
  input wire logic rstn_i,  // reset, low
  input wire logic read_i,  // read
  input wire logic write_i,  // write
  input wire logic [31:0] readdata_o,  // read data
  input wire logic waitrequest_o,  // stall
  input wire logic port0_tx_pin_o,  // tx pin
  input wire logic port0_data_pin_oe_o,  // data drive
  input wire logic port0_tx_done_o,  // flag
  input wire logic port0_rx_done_o,  // flag
  input wire logic port1_tx_done_o,  // flag
  input wire logic port1_rx_done_o  // flag
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  wait_one_a: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("bus answer late");
  wait_pulse_a: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("waitrequest low too long");
  read_upper_a: assert property (!waitrequest_o |-> readdata_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  tx0_hold_a: assert property ($fell(port0_tx_done_o) |-> $past(write_i) || $past(write_i, 2))
    else $error("tx flag 0 cleared without a write");
  rx0_hold_a: assert property ($fell(port0_rx_done_o) |-> $past(write_i) || $past(write_i, 2))
    else $error("rx flag 0 cleared without a write");
  tx1_hold_a: assert property ($fell(port1_tx_done_o) |-> $past(write_i) || $past(write_i, 2))
    else $error("tx flag 1 cleared without a write");
  rx1_hold_a: assert property ($fell(port1_rx_done_o) |-> $past(write_i) || $past(write_i, 2))
    else $error("rx flag 1 cleared without a write");
  stop_high_a: assert property ($rose(port0_tx_done_o) |-> port0_tx_pin_o)
    else $error("tx flag raised off the stop bit");
  m0_start_a: assert property ($rose(port0_data_pin_oe_o) |-> !port0_tx_pin_o)
    else $error("mode 0 clock not low at start");
  m0_end_a: assert property ($fell(port0_data_pin_oe_o) |-> ##[0:1] port0_tx_done_o)
    else $error("mode 0 end without tx flag");
endmodule : serial_checker
bind dual_serial_port_control serial_checker chk_i (.mclk_i, .rstn_i, .read_i, .write_i, .readdata_o,
  .waitrequest_o, .port0_tx_pin_o, .port0_data_pin_oe_o, .port0_tx_done_o, .port0_rx_done_o,
  .port1_tx_done_o, .port1_rx_done_o);
`default_nettype wire

// ==== sim/serial_partner.sv ====
/* far-side serial sender: one frame of start, nine bits and stop per go pulse.
   assumes go_i pulses for one cycle while the sender is idle. */
`timescale 1ns/100ps
`default_nettype none
module serial_partner (
  input wire logic clk_i,  // system clock
  input wire logic go_i,  // send one frame
  input wire logic [8:0] word_i,  // ninth bit and data
  input wire logic [7:0] bit_clks_i,  // clocks per bit
  output logic line_o,  // serial line, idles high
  output logic busy_o  // frame in progress
);
  logic [10:0] frame;
  initial begin
    line_o = 1'b1;
    busy_o = 1'b0;
  end
  always begin
    @(posedge clk_i);
    if (go_i) begin
      frame = {1'b1, word_i, 1'b0};  // start, data lsb first, ninth, stop
      busy_o <= 1'b1;
      for (int i = 0; i < 11; i++) begin
        line_o <= frame[i];
        repeat (bit_clks_i) @(posedge clk_i);
      end
      busy_o <= 1'b0;
    end
  end
endmodule : serial_partner
`default_nettype wire

// ==== sim/dual_serial_port_control_tb.sv ====
/* self-checking bench for dual_serial_port_control.
   assumes the bound checker and the far-side sender on port 1. */
`timescale 1ns/100ps
`default_nettype none
module dual_serial_port_control_tb;
  typedef struct packed {logic [7:0] ctl; logic [8:0] word; logic flag; logic [7:0] rx; logic [7:0] ectl;} row_s;
  logic mclk_i = 1'b0, rstn_i = 1'b0, read_i = 1'b0, write_i = 1'b0, go = 1'b0, busy, line, prev = 1'b1;
  logic [9:0] address_i = 10'h000;
  logic [31:0] writedata_i = 32'h0, readdata_o;
  logic [3:0] byteenable_i = 4'hF;
  logic [1:0] sample_tick_i = 2'h0, double_rate_i = 2'h3;
  logic waitrequest_o, port0_tx_pin_o, port0_data_pin_o, port0_data_pin_oe_o, port0_tx_done_o, port0_rx_done_o;
  logic port1_tx_pin_o, port1_data_pin_o, port1_data_pin_oe_o, port1_tx_done_o, port1_rx_done_o;
  logic [7:0] q, sh;
  logic [8:0] w = 9'h000;
  logic [10:0] f = {1'b1, 1'b1, 8'hA5, 1'b0};
  int miscompares = 0, n_checks = 0, cyc = 0, rises = 0, per = 0, t0 = 0;
  wire logic port0_data_pin_i = port0_data_pin_oe_o ? port0_data_pin_o : 1'b1;  // pulled high when released
  wire logic port1_data_pin_i = port1_data_pin_oe_o ? port1_data_pin_o : line;
  logic [9:0] addrs [5] = '{10'h260, 10'h264, 10'h300, 10'h304, 10'h3FC};
  // last two rows are mode 1 with multiprocessor bit: stop bit is word bit 8
  row_s rows [7] = '{'{8'hA0, 9'h111, 1'b0, 8'h00, 8'hA0}, '{8'h90, 9'h0C3, 1'b1, 8'hC3, 8'h91},
    '{8'hB0, 9'h03C, 1'b0, 8'hC3, 8'hB0}, '{8'hB0, 9'h13C, 1'b1, 8'h3C, 8'hB5}, '{8'hB5, 9'h155, 1'b1, 8'h3C, 8'hB5},
    '{8'h70, 9'h15A, 1'b1, 8'h5A, 8'h75}, '{8'h70, 9'h0A5, 1'b0, 8'h5A, 8'h70}};
  always #50 mclk_i = ~mclk_i;
  dual_serial_port_control dut (.mclk_i, .rstn_i, .address_i, .read_i, .write_i, .writedata_i, .byteenable_i,
    .readdata_o, .waitrequest_o, .sample_tick_i, .double_rate_i, .port0_tx_pin_o, .port0_data_pin_i,
    .port0_data_pin_o, .port0_data_pin_oe_o, .port0_tx_done_o, .port0_rx_done_o, .port1_tx_pin_o,
    .port1_data_pin_i, .port1_data_pin_o, .port1_data_pin_oe_o, .port1_tx_done_o, .port1_rx_done_o);
  serial_partner far (.clk_i(mclk_i), .go_i(go), .word_i(w), .bit_clks_i(8'h20), .line_o(line), .busy_o(busy));
  // mode 0 monitor: data taken at each rising bit clock
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    // port 1 sample tick every second clock, 32 clocks per bit like the sender
    sample_tick_i <= {~sample_tick_i[1], 1'b0};
    prev <= port0_tx_pin_o;
    if (port0_tx_pin_o && !prev && port0_data_pin_oe_o) begin
      sh <= {port0_data_pin_o, sh[7:1]};
      per <= cyc - t0;
      t0 <= cyc;
      rises <= rises + 1;
    end
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
    write_i <= wr;
    read_i <= !wr;
    address_i <= a;
    writedata_i <= {24'h0, d};
    @(posedge mclk_i);
    while (waitrequest_o !== 1'b0) @(posedge mclk_i);
    q = readdata_o[7:0];
    write_i <= 1'b0;
    read_i <= 1'b0;
    @(posedge mclk_i);
  endtask : bus
  task automatic rchk(input logic [9:0] a, input logic [7:0] e, input string n);
    bus(1'b0, a, 8'h00);
    chk(n, q, e);
  endtask : rchk
  task automatic summarize;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (6) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    foreach (rows[i]) begin
      bus(1'b1, 10'h300, rows[i].ctl);
      w <= rows[i].word;
      go <= 1'b1;
      @(posedge mclk_i);
      go <= 1'b0;
      @(posedge mclk_i);
      while (busy) @(posedge mclk_i);
      chk("rx flag", {7'h0, port1_rx_done_o}, {7'h0, rows[i].flag});
      rchk(10'h304, rows[i].rx, "rx byte");
      rchk(10'h300, rows[i].ectl, "rx control");
    end
    bus(1'b1, 10'h300, 8'h00);
    rstn_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    foreach (addrs[i]) rchk(addrs[i], 8'h00, "reset value");
    chk("port1 idle pins", {6'h0, port1_tx_pin_o, port1_data_pin_oe_o}, 8'h02);
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, p ? 10'h300 : 10'h260, 8'h4B);
      rchk(p ? 10'h300 : 10'h260, 8'h4B, "control");
      chk("flags", p ? {6'h0, port1_tx_done_o, port1_rx_done_o} : {6'h0, port0_tx_done_o, port0_rx_done_o}, 8'h03);
      bus(1'b1, p ? 10'h300 : 10'h260, 8'h00);
    end
    bus(1'b1, 10'h3FC, 8'h77);
    rchk(10'h3FC, 8'h00, "unmapped");
    bus(1'b1, 10'h260, 8'h88);
    bus(1'b1, 10'h264, 8'hA5);
    while (port0_tx_pin_o !== 1'b0) @(posedge mclk_i);
    repeat (16) @(posedge mclk_i);
    for (int k = 0; k < 11; k++) begin
      chk("tx bit", {7'h0, port0_tx_pin_o}, {7'h0, f[k]});
      chk("tx flag", {7'h0, port0_tx_done_o}, {7'h0, k == 10});
      repeat (32) @(posedge mclk_i);
    end
    bus(1'b1, 10'h260, 8'h00);
    for (int m = 0; m < 2; m++) begin
      rises = 0;
      bus(1'b1, 10'h260, m ? 8'h20 : 8'h00);
      bus(1'b1, 10'h264, 8'h96);
      while (rises < 8) @(posedge mclk_i);
      while (port0_data_pin_oe_o !== 1'b0) @(posedge mclk_i);
      @(posedge mclk_i);
      chk("m0 byte", sh, 8'h96);
      chk("m0 period", 8'(per), m ? 8'h04 : 8'h0C);
      chk("m0 flag", {7'h0, port0_tx_done_o}, 8'h01);
      bus(1'b1, 10'h260, 8'h00);
    end
    // mode 0 receive: released data pin is pulled high, so all ones arrive
    bus(1'b1, 10'h260, 8'h10);
    while (port0_rx_done_o !== 1'b1) @(posedge mclk_i);
    rchk(10'h264, 8'hFF, "m0 rx byte");
    rchk(10'h260, 8'h11, "m0 rx control");
    bus(1'b1, 10'h260, 8'h00);
    summarize();
  end
endmodule : dual_serial_port_control_tb
`default_nettype wire
